// File: rtl/gpiop_port.v
// Contract
// - port holds direction, level, latch, threshold, open-drain, slew regs
// - analog select and weak pull-up exist only when enabled by parameter
// - enabled peripheral owns its pin driver; the pin level stays readable
// - writing the latch register updates the latch like a level write
// - latch read returns stored latch; level read returns pin levels
// - analog select bit set disables that pin's digital input buffer
// - port is eight bidirectional pins: direction, latch, level per pin
// - direction one makes the pin an input, driver off
// - direction zero drives the latch bit onto the pin
// - level writes replace the latch: pin sample masked out, data latched
// - direction still controls drivers on analog pins
// - analog pins read zero through the level register
// - open-drain set: drive low for zero, release for one
// - open-drain clear: push-pull drives both levels
// - open-drain is selected per pin independently
// - analog select one means analog, zero digital; resets to one
`timescale 1ns/1ns
`default_nettype none
`include "gpiop_defines.vh"

module gpiop_port #(
    parameter WIDTH      = 8,
    parameter HAS_ANALOG = 1,
    parameter HAS_PULLUP = 1
) (
    // apb clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // apb slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [31:0]      paddr,
    input  wire [31:0]      pwdata,
    input  wire [3:0]       pstrb,
    output reg  [31:0]      prdata,
    output wire             pready,
    output reg              pslverr,
    // peripheral override, same clock domain
    input  wire [WIDTH-1:0] periph_en,
    input  wire [WIDTH-1:0] periph_out,
    input  wire [WIDTH-1:0] periph_oe,
    // pin levels seen by peripherals
    output reg  [WIDTH-1:0] pin_level_out,
    // pads
    input  wire [WIDTH-1:0] pad_in,
    output reg  [WIDTH-1:0] pad_out,
    output reg  [WIDTH-1:0] pad_oe,
    output reg  [WIDTH-1:0] pad_ibuf_dis,
    output reg  [WIDTH-1:0] pad_pullup_en,
    output reg  [WIDTH-1:0] pad_threshold,
    output reg  [WIDTH-1:0] pad_slew_limit
);

////////////////////////////////////////////////////////////////////////////
// pad input synchroniser

reg  [WIDTH-1:0] pin_meta_q;
reg  [WIDTH-1:0] pin_sync_q;

// pad levels are asynchronous to pclk
// first stage is read only by the second
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pin_meta_q <= {WIDTH{1'b0}};
        pin_sync_q <= {WIDTH{1'b0}};
    end
    else
    begin
        pin_meta_q <= pad_in;
        pin_sync_q <= pin_meta_q;
    end
end

////////////////////////////////////////////////////////////////////////////
// registers

reg  [WIDTH-1:0] pin_direction_reg_q;
reg  [WIDTH-1:0] output_latch_reg_q;
reg  [WIDTH-1:0] input_threshold_reg_q;
reg  [WIDTH-1:0] open_drain_select_reg_q;
reg  [WIDTH-1:0] slew_limit_reg_q;
reg  [WIDTH-1:0] analog_select_reg_q;
reg  [WIDTH-1:0] weak_pullup_reg_q;

wire [WIDTH-1:0] analog_eff;
wire [WIDTH-1:0] pullup_eff;
wire [WIDTH-1:0] pin_level_reg;

// absent registers behave as all digital, no pull-up
assign analog_eff = (HAS_ANALOG != 0) ? analog_select_reg_q
                                      : {WIDTH{1'b0}};
assign pullup_eff = (HAS_PULLUP != 0) ? weak_pullup_reg_q
                                      : {WIDTH{1'b0}};

// disabled input buffer reads as zero
assign pin_level_reg = pin_sync_q & ~analog_eff;

////////////////////////////////////////////////////////////////////////////
// apb decode

wire [`GPIOP_ADDR_W-1:0] addr;
wire                     setup_ph;
wire                     wr_en;
reg                      addr_hit;
wire                     upper_zero;

assign addr     = paddr[`GPIOP_ADDR_W-1:0];
// every address bit above the decoded window must be zero to hit
assign upper_zero = (paddr[31:`GPIOP_ADDR_W]
                     == {(32-`GPIOP_ADDR_W){1'b0}});
assign setup_ph = psel & ~penable;
// zero wait state slave
assign pready   = 1'b1;
// lane 0 carries all data; other lanes are ignored
assign wr_en    = psel & penable & pready & pwrite & pstrb[0];

always @*
begin
    case (addr)
        `GPIOP_OFS_DIRECTION,
        `GPIOP_OFS_LEVEL,
        `GPIOP_OFS_LATCH,
        `GPIOP_OFS_THRESHOLD,
        `GPIOP_OFS_OPEN_DRAIN,
        `GPIOP_OFS_SLEW:
            addr_hit = upper_zero;
        `GPIOP_OFS_ANALOG:
            addr_hit = upper_zero
                       && (HAS_ANALOG != 0);
        `GPIOP_OFS_PULLUP:
            addr_hit = upper_zero
                       && (HAS_PULLUP != 0);
        default:
            // misaligned or unknown offsets are refused
            addr_hit = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////////
// register writes

wire [WIDTH-1:0] wdata;
wire             wr_hit;

assign wdata  = pwdata[WIDTH-1:0];
assign wr_hit = wr_en & addr_hit;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        // all inputs after reset, so nothing is driven before setup
        pin_direction_reg_q     <= `GPIOP_RST_DIRECTION;
        output_latch_reg_q      <= `GPIOP_RST_LATCH;
        input_threshold_reg_q   <= `GPIOP_RST_THRESHOLD;
        open_drain_select_reg_q <= `GPIOP_RST_OPEN_DRAIN;
        slew_limit_reg_q        <= `GPIOP_RST_SLEW;
        analog_select_reg_q     <= `GPIOP_RST_ANALOG;
        weak_pullup_reg_q       <= `GPIOP_RST_PULLUP;
    end
    else if (wr_hit)
    begin
        case (addr)
            `GPIOP_OFS_DIRECTION:
                pin_direction_reg_q <= wdata;
            `GPIOP_OFS_LEVEL:
                // full byte written, so the merged pin sample is replaced
                output_latch_reg_q <= (pin_level_reg & ~{WIDTH{1'b1}})
                                      | wdata;
            `GPIOP_OFS_LATCH:
                output_latch_reg_q <= wdata;
            `GPIOP_OFS_THRESHOLD:
                input_threshold_reg_q <= wdata;
            `GPIOP_OFS_OPEN_DRAIN:
                open_drain_select_reg_q <= wdata;
            `GPIOP_OFS_SLEW:
                slew_limit_reg_q <= wdata;
            `GPIOP_OFS_ANALOG:
                analog_select_reg_q <= wdata;
            `GPIOP_OFS_PULLUP:
                weak_pullup_reg_q <= wdata;
            default:
                pin_direction_reg_q <= pin_direction_reg_q;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// register reads, captured in the setup cycle

reg  [WIDTH-1:0] rd_mux;

always @*
begin
    case (addr)
        `GPIOP_OFS_DIRECTION:  rd_mux = pin_direction_reg_q;
        `GPIOP_OFS_LEVEL:      rd_mux = pin_level_reg;
        `GPIOP_OFS_LATCH:      rd_mux = output_latch_reg_q;
        `GPIOP_OFS_THRESHOLD:  rd_mux = input_threshold_reg_q;
        `GPIOP_OFS_OPEN_DRAIN: rd_mux = open_drain_select_reg_q;
        `GPIOP_OFS_SLEW:       rd_mux = slew_limit_reg_q;
        `GPIOP_OFS_ANALOG:     rd_mux = analog_eff;
        `GPIOP_OFS_PULLUP:     rd_mux = pullup_eff;
        default:               rd_mux = {WIDTH{1'b0}};
    endcase
end

// read data is a flop, so it is loaded one cycle early
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata  <= `GPIOP_ZERO32;
        pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
        pslverr <= ~addr_hit;
        if (!pwrite && addr_hit)
        begin
            prdata <= {{(32-WIDTH){1'b0}}, rd_mux};
        end
        else
        begin
            // refused accesses read zero so no stale value reaches software
            prdata <= `GPIOP_ZERO32;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// pad drive

reg  [WIDTH-1:0] drv_out_d;
reg  [WIDTH-1:0] drv_oe_d;
integer          i;

always @*
begin
    drv_out_d = {WIDTH{1'b0}};
    drv_oe_d  = {WIDTH{1'b0}};
    for (i = 0; i < WIDTH; i = i + 1)
    begin
        if (periph_en[i])
        begin
            // general purpose latch cannot reach this pin
            drv_out_d[i] = periph_out[i];
            drv_oe_d[i]  = periph_oe[i];
        end
        else if (pin_direction_reg_q[i])
        begin
            // analog pins get no exception here
            drv_oe_d[i] = 1'b0;
        end
        else if (open_drain_select_reg_q[i])
        begin
            // a one releases the pin; pull-up or outside sets the level
            drv_out_d[i] = 1'b0;
            drv_oe_d[i]  = ~output_latch_reg_q[i];
        end
        else
        begin
            drv_out_d[i] = output_latch_reg_q[i];
            drv_oe_d[i]  = 1'b1;
        end
    end
end

// pads see configuration one cycle after the write
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pad_out        <= {WIDTH{1'b0}};
        pad_oe         <= {WIDTH{1'b0}};
        // a port without analog select never disables its input buffers
        pad_ibuf_dis   <= (HAS_ANALOG != 0) ? {WIDTH{1'b1}}
                                            : {WIDTH{1'b0}};
        pad_pullup_en  <= {WIDTH{1'b0}};
        pad_threshold  <= {WIDTH{1'b0}};
        pad_slew_limit <= {WIDTH{1'b0}};
        pin_level_out  <= {WIDTH{1'b0}};
    end
    else
    begin
        pad_out        <= drv_out_d;
        pad_oe         <= drv_oe_d;
        pad_ibuf_dis   <= analog_eff;
        // pull-up only on pins not driven
        pad_pullup_en  <= pullup_eff & ~drv_oe_d;
        pad_threshold  <= input_threshold_reg_q;
        pad_slew_limit <= slew_limit_reg_q;
        pin_level_out  <= pin_level_reg;
    end
end

endmodule
`default_nettype wire

// File: rtl/gpiop_defines.vh
`ifndef GPIOP_DEFINES_VH
`define GPIOP_DEFINES_VH

// apb byte offsets, one aligned word each
`define GPIOP_OFS_DIRECTION  12'h000
`define GPIOP_OFS_LEVEL      12'h004
`define GPIOP_OFS_LATCH      12'h008
`define GPIOP_OFS_THRESHOLD  12'h00C
`define GPIOP_OFS_OPEN_DRAIN 12'h010
`define GPIOP_OFS_SLEW       12'h014
`define GPIOP_OFS_ANALOG     12'h018
`define GPIOP_OFS_PULLUP     12'h01C

// address decode width
`define GPIOP_ADDR_W         12

// reset values, port is 8 pins wide
`define GPIOP_RST_DIRECTION  8'hFF
`define GPIOP_RST_LATCH      8'h00
`define GPIOP_RST_THRESHOLD  8'h00
`define GPIOP_RST_OPEN_DRAIN 8'h00
`define GPIOP_RST_SLEW       8'h00
`define GPIOP_RST_ANALOG     8'hFF
`define GPIOP_RST_PULLUP     8'h00

// register data field position
`define GPIOP_FLD_LSB        0
`define GPIOP_FLD_MSB        7

// misc constants
`define GPIOP_ZERO32         32'h0000_0000
`define GPIOP_ZERO8          8'h00
`define GPIOP_ONES8          8'hFF

`endif

// File: bench/gpiop_pads_model.sv
`timescale 1ns/1ns
`default_nettype none
module gpiop_pads_model (
    // pattern clock for floating pins
    input  wire logic       pclk,
    // pad side of the port
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pullup_en,
    // outside driver
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_drv,
    output logic      [7:0] pad_in
);
    logic tgl_q = 1'b0;
    // a floating pin toggles so a stale level never passes as a match
    always @(posedge pclk)
        tgl_q <= ~tgl_q;
    // released pin falls to outside driver, pull-up, else floats
    always_comb
        for (int i = 0; i < 8; i++)
            pad_in[i] = pad_oe[i] ? pad_out[i] :
                ext_drv[i] ? ext_val[i] : pad_pullup_en[i] | tgl_q;
endmodule
`default_nettype wire

// File: bench/gpiop_chk_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpiop_defines.vh"
module gpiop_chk (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // peripheral and pads
    input wire logic [7:0]  periph_en,
    input wire logic [7:0]  periph_oe,
    input wire logic [7:0]  pin_level_out,
    input wire logic [7:0]  pad_in,
    input wire logic [7:0]  pad_oe,
    input wire logic [7:0]  pad_ibuf_dis,
    input wire logic [7:0]  pad_threshold
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_wr(logic [31:0] a);
        psel && penable && pwrite && pstrb[0] && paddr == a;
    endsequence
    // level path is only judged once the analog mask has settled
    sequence s_quiet; $stable(pad_ibuf_dis)[*4]; endsequence
AST_REFUSE: assert property (psel && !penable && paddr[31:5] != 0
    |=> pslverr && prdata == 0) else $error("unmapped access passed");
AST_MAPPED: assert property (s_setup ##0 paddr[31:5] == 0
    && paddr[1:0] == 0 |=> !pslverr) else $error("mapped access refused");
AST_HOLD: assert property (s_setup ##1 penable ##1 1'b1
    |-> $stable(prdata)) else $error("read data moved in access");
AST_UPPER: assert property (prdata[31:8] == 0)
    else $error("read data above bit 7");
AST_PERIPH: assert property (|$past(periph_en) |->
    ((pad_oe ^ $past(periph_oe)) & $past(periph_en)) == 0)
    else $error("peripheral lost its pin");
AST_LEVEL: assert property (s_quiet |->
    pin_level_out == ($past(pad_in, 3) & ~pad_ibuf_dis))
    else $error("pin level path wrong");
AST_THR: assert property (s_wr(`GPIOP_OFS_THRESHOLD) |-> ##2
    pad_threshold == $past(pwdata[7:0], 2)) else $error("threshold lost");
AST_ANA: assert property (s_wr(`GPIOP_OFS_ANALOG) |-> ##2
    pad_ibuf_dis == $past(pwdata[7:0], 2)) else $error("ibuf not set");
endmodule
////////////////////////////////////////
bind gpiop_port gpiop_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
    .periph_en(periph_en), .periph_oe(periph_oe), .pad_in(pad_in),
    .pin_level_out(pin_level_out), .pad_oe(pad_oe),
    .pad_ibuf_dis(pad_ibuf_dis), .pad_threshold(pad_threshold));
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpiop_defines.vh"
module tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, ready, err, e;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, rdata, r;
    logic [3:0]  pstrb = 4'hF;
    logic [7:0]  pen = 8'h00, pout = 8'h00, poe = 8'h00;
    logic [7:0]  ext_val = 8'h00, ext_drv = 8'h00;
    logic [7:0]  lvl, pin, out, oe, ibuf, pull, thr, slew;
    int          num_errors = 0, comparisons = 0;
    always #2 pclk = ~pclk;
    gpiop_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(rdata), .pready(ready), .pslverr(err),
        .periph_en(pen), .periph_out(pout), .periph_oe(poe),
        .pin_level_out(lvl), .pad_in(pin), .pad_out(out), .pad_oe(oe),
        .pad_ibuf_dis(ibuf), .pad_pullup_en(pull), .pad_threshold(thr),
        .pad_slew_limit(slew));
    gpiop_pads_model i_pads (.pclk(pclk), .pad_out(out), .pad_oe(oe),
        .pad_pullup_en(pull), .ext_val(ext_val), .ext_drv(ext_drv),
        .pad_in(pin));
    task automatic chk(input string n, input logic [7:0] g, x);
        comparisons++;
        if (g !== x)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d, input logic s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {20'h0_0000, a};
        pwdata <= {24'h00_0000, d};
        pstrb <= {3'h7, s};
        @(posedge pclk);
        penable <= 1'b1;
        // hold the request until ready is seen at an edge
        for (n = 0; n < 50; n++)
        begin
            @(posedge pclk);
            if (ready === 1'b1)
                break;
        end
        r = rdata;
        e = err;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50)
        begin
            num_errors++;
            tally_and_finish;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 1'b1);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] x, xe);
        apb(1'b0, a, 8'h00, 1'b1);
        chk("rdata", r[7:0], x);
        chk("slverr", {7'h00, e}, {7'h00, xe[0]});
    endtask
    // pads settle one edge after a write, level needs two more for sync
    task automatic settle(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask
    task automatic t_reset;
        logic [7:0] rv [8];
        rv = '{`GPIOP_RST_DIRECTION, 8'h00, `GPIOP_RST_LATCH,
               `GPIOP_RST_THRESHOLD, `GPIOP_RST_OPEN_DRAIN, `GPIOP_RST_SLEW,
               `GPIOP_RST_ANALOG, `GPIOP_RST_PULLUP};
        chk("oe", oe, 8'h00);
        chk("ibuf", ibuf, 8'hFF);
        for (int i = 0; i < 8; i++)
            rd(12'(i * 4), rv[i], 8'h00);
        rd(12'h020, 8'h00, 8'h01);
    endtask
    task automatic t_out;
        wr(`GPIOP_OFS_ANALOG, 8'h00);
        wr(`GPIOP_OFS_DIRECTION, 8'h00);
        wr(`GPIOP_OFS_LATCH, 8'hA5);
        settle(5);
        chk("oe", oe, 8'hFF);
        chk("out", out, 8'hA5);
        rd(`GPIOP_OFS_LEVEL, 8'hA5, 8'h00);
        wr(`GPIOP_OFS_LEVEL, 8'h3C);
        rd(`GPIOP_OFS_LATCH, 8'h3C, 8'h00);
        wr(`GPIOP_OFS_OPEN_DRAIN, 8'h0F);
        wr(`GPIOP_OFS_LATCH, 8'h55);
        settle(2);
        chk("oe", oe, 8'hFA);
        chk("out", out, 8'h50);
    endtask
    task automatic t_in;
        wr(`GPIOP_OFS_OPEN_DRAIN, 8'h00);
        wr(`GPIOP_OFS_DIRECTION, 8'hFF);
        ext_drv <= 8'hFF;
        ext_val <= 8'h96;
        settle(5);
        chk("oe", oe, 8'h00);
        chk("lvl", lvl, 8'h96);
        rd(`GPIOP_OFS_LEVEL, 8'h96, 8'h00);
        rd(`GPIOP_OFS_LATCH, 8'h55, 8'h00);
        wr(`GPIOP_OFS_ANALOG, 8'h0F);
        settle(5);
        chk("ibuf", ibuf, 8'h0F);
        chk("lvl", lvl, 8'h90);
        rd(`GPIOP_OFS_LEVEL, 8'h90, 8'h00);
        wr(`GPIOP_OFS_DIRECTION, 8'hF0);
        settle(2);
        chk("oe", oe, 8'h0F);
    endtask
    task automatic t_periph;
        wr(`GPIOP_OFS_ANALOG, 8'h00);
        wr(`GPIOP_OFS_DIRECTION, 8'h00);
        pen <= 8'h0F;
        pout <= 8'h0A;
        poe <= 8'h03;
        settle(5);
        chk("oe", oe, 8'hF3);
        chk("out", out & 8'hF3, 8'h52);
        chk("lvl", lvl, 8'h56);
        rd(`GPIOP_OFS_LEVEL, 8'h56, 8'h00);
        wr(`GPIOP_OFS_THRESHOLD, 8'hC3);
        wr(`GPIOP_OFS_SLEW, 8'h3C);
        apb(1'b1, `GPIOP_OFS_THRESHOLD, 8'h00, 1'b0);
        wr(`GPIOP_OFS_PULLUP, 8'hF0);
        settle(2);
        chk("thr", thr, 8'hC3);
        chk("slew", slew, 8'h3C);
        chk("pull", pull, 8'h00);
        rd(`GPIOP_OFS_LEVEL, 8'h56, 8'h00);
        wr(`GPIOP_OFS_DIRECTION, 8'hFF);
        pen <= 8'h00;
        settle(2);
        chk("pull", pull, 8'hF0);
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
        t_reset;
        t_out;
        t_in;
        t_periph;
        // second reset in mid-run: every register back to its reset value
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
        t_reset;
        tally_and_finish;
    end
endmodule
`default_nettype wire
